/* File: verilog/txpcs_params.svh */
// Overview of operation
// [R1] While power_down_n is low the block is shut down: synthesizer off, no channel work, no ready indication.
// [R2] When power_down_n is high the block powers up and heads for normal transmit operation; the code stays off while the CTRL hold bit is set.
// [R3] The start-up sequence runs after reset (supply applied) and on every low-to-high change of power_down_n; code waits while CTRL hold is set.
// [R4] Start-up samples the channel from the parallel lines or the serial loader, per mode, and programs the synthesizer.
// [R5] ready_to_send rises only once the synthesizer reports lock on the programmed channel.
// [R6] The host grounds the mode input to choose parallel selection; the channel then comes from the three select lines.
// [R7] Parallel mode decodes chan_sel_bit2..0 as a binary channel 0 to 7, bit 2 most significant.
// [R8] The host drives a select line to ground for zero and to the supply for one.
// [R9] Mode input open or high selects serial mode: chan_sel_bit1 is the serial clock, chan_sel_bit2 the serial data.
// [R10] After power-up in serial mode the channel is 50 until the host loads one.
// [R11] A host ignoring ready_to_send waits at least 10 ms after raising power_down_n before sending data.
// [R12] ready_to_send stays low through power-down and start-up until lock is reached.
`ifndef TXPCS_PARAMS_SVH
`define TXPCS_PARAMS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define TXPCS_REG_CTRL       4'h0
`define TXPCS_REG_STATUS     4'h4
`define TXPCS_REG_INT_STAT   4'h8
`define TXPCS_REG_INT_MASK   4'hc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TXPCS_CTRL_HOLD      0
`define TXPCS_CTRL_RESTART   1
`define TXPCS_ST_RTS         0
`define TXPCS_ST_SERIAL      1
`define TXPCS_ST_LOCK        2
`define TXPCS_ST_STATE_LO    4
`define TXPCS_ST_CHAN_LO     16
`define TXPCS_EV_LOCKED      0
`define TXPCS_EV_LOCK_LOST   1
`define TXPCS_EV_SER_LOAD    2
`define TXPCS_EV_SER_ERR     3
`define TXPCS_EV_TIMEOUT     4
`define TXPCS_EV_W           5

// ----------------------------------------
// Channels and timing
// ----------------------------------------
`define TXPCS_SER_DEF_CHAN   8'h32
`define TXPCS_SER_MAX_CHAN   8'h64
`define TXPCS_SER_ERR_CHAN   8'h00
`define TXPCS_SER_BITS       4'h8
`define TXPCS_CLK_HZ         25000000
`define TXPCS_LOCK_TMO_MS    10
`define TXPCS_LOCK_TMO_CYC   ((`TXPCS_LOCK_TMO_MS * `TXPCS_CLK_HZ) / 1000)

`endif

/* File: verilog/txpcs_pkg.sv */
package txpcs_pkg;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_OFF   = 5'b00001,
    ST_START = 5'b00010,
    ST_PROG  = 5'b00100,
    ST_WAIT  = 5'b01000,
    ST_READY = 5'b10000
  } txpcs_state_t;

endpackage

/* File: verilog/txpcs_ser_if.sv */
`timescale 1ns/1ns
interface txpcs_ser_if;
  logic       clk_lvl;
  logic       data_lvl;
  logic       enable;
  logic       load;
  logic [7:0] chan;
  logic       err;

  modport ctl (output clk_lvl, output data_lvl, output enable, input load, input chan, input err);
  modport rx  (input clk_lvl, input data_lvl, input enable, output load, output chan, output err);
endinterface

/* File: verilog/txpcs_ser_rx.sv */
`timescale 1ns/1ns
`include "txpcs_params.svh"
module txpcs_ser_rx (
  // Clock and reset
  input wire logic  sys_clk,
  input wire logic  resetn,
  // Serial lines and load result
  txpcs_ser_if.rx   ser
);

  logic       clk_d;
  logic       active;
  logic [3:0] cnt;
  logic [7:0] shreg;

  // ----------------------------------------
  // Serial channel loader
  // ----------------------------------------
  // Start: clock high with data low; eight bits LSB first on clock rises;
  // then clock and data both high latch the number.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_d    <= 1'b0;
      active   <= 1'b0;
      cnt      <= 4'h0;
      shreg    <= 8'h00;
      ser.load <= 1'b0;
      ser.chan <= `TXPCS_SER_DEF_CHAN;
      ser.err  <= 1'b0;
    end else begin
      clk_d    <= ser.clk_lvl;
      ser.load <= 1'b0;
      ser.err  <= 1'b0;
      if (!ser.enable) begin
        active <= 1'b0; // [R1]
        cnt    <= 4'h0;
      end else if (!active) begin
        if (ser.clk_lvl && !ser.data_lvl) begin // [R9]
          active <= 1'b1;
          cnt    <= 4'h0;
        end
      end else if (cnt != `TXPCS_SER_BITS) begin
        if (ser.clk_lvl && !clk_d) begin
          shreg <= {ser.data_lvl, shreg[7:1]};
          cnt   <= cnt + 4'h1;
        end
      end else if (ser.clk_lvl && ser.data_lvl) begin
        active   <= 1'b0;
        ser.load <= 1'b1;
        // Out-of-range numbers fall back to channel 0 so activity is visible
        if (shreg > `TXPCS_SER_MAX_CHAN) begin
          ser.chan <= `TXPCS_SER_ERR_CHAN;
          ser.err  <= 1'b1;
        end else begin
          ser.chan <= shreg;
        end
      end
    end
  end

endmodule // txpcs_ser_rx

/* File: verilog/txpcs_top.sv */
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "txpcs_params.svh"
module txpcs_top #(
  parameter int LOCK_TMO_CYC = `TXPCS_LOCK_TMO_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Control pins to and from the host
  input  wire logic        power_down_n,
  input  wire logic        mode_sel,
  input  wire logic        chan_sel_bit0,
  input  wire logic        chan_sel_bit1,
  input  wire logic        chan_sel_bit2,
  output logic             ready_to_send,
  // Synthesizer
  input  wire logic        pll_lock,
  output logic             pll_enable,
  output logic             pll_prog,
  output logic [7:0]       pll_chan,
  output logic             pll_serial,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq
);

  localparam int TW = $clog2(LOCK_TMO_CYC + 1);
  localparam int NPIN = 6;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Reset value 0 makes a pin already high at reset look like a rising
  // power_down_n, so supply-on and pin release share one start path.
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m;
  logic [NPIN-1:0] pin_s;

  assign pin_raw = {pll_lock, mode_sel, chan_sel_bit2, chan_sel_bit1, chan_sel_bit0, power_down_n};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          pin_m[gi] <= 1'b0;
          pin_s[gi] <= 1'b0;
        end else begin
          pin_m[gi] <= pin_raw[gi];
          pin_s[gi] <= pin_m[gi];
        end
      end
    end
  endgenerate

  logic       pdn_s;
  logic       mode_s;
  logic [2:0] sel_s;
  logic       lock_s;

  assign pdn_s  = pin_s[0];
  assign sel_s  = pin_s[3:1];
  assign mode_s = pin_s[4];
  assign lock_s = pin_s[5];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic                  ctrl_hold;
  logic                  restart;
  logic [`TXPCS_EV_W-1:0] int_stat;
  logic [`TXPCS_EV_W-1:0] int_mask;
  logic [`TXPCS_EV_W-1:0] ev;
  logic                  wr_ctrl;
  logic                  wr_stat;

  assign wr_ctrl = reg_wr && (reg_addr == `TXPCS_REG_CTRL);
  assign wr_stat = reg_wr && (reg_addr == `TXPCS_REG_INT_STAT);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_hold <= 1'b0;
      restart   <= 1'b0;
    end else begin
      restart <= wr_ctrl && reg_wdata[`TXPCS_CTRL_RESTART];
      if (wr_ctrl) begin
        ctrl_hold <= reg_wdata[`TXPCS_CTRL_HOLD];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      int_mask <= '0;
    end else if (reg_wr && (reg_addr == `TXPCS_REG_INT_MASK)) begin
      int_mask <= reg_wdata[`TXPCS_EV_W-1:0];
    end
  end

  // A new event in the clearing cycle survives the write-one clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat & ~(wr_stat ? reg_wdata[`TXPCS_EV_W-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_stat & ~(wr_stat ? reg_wdata[`TXPCS_EV_W-1:0] : '0)) | ev) & int_mask);
    end
  end

  // ----------------------------------------
  // Serial loader
  // ----------------------------------------
  txpcs_ser_if ser ();
  txpcs_pkg::txpcs_state_t state;

  assign ser.clk_lvl  = sel_s[1]; // [R9]
  assign ser.data_lvl = sel_s[2]; // [R9]
  assign ser.enable   = (state != txpcs_pkg::ST_OFF) && mode_s;

  txpcs_ser_rx u_ser_rx (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ser     (ser)
  );

  // Channel the serial side would use; back to the default on every power-up
  logic [7:0] ser_chan;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ser_chan <= `TXPCS_SER_DEF_CHAN;
    end else if (state == txpcs_pkg::ST_OFF) begin
      ser_chan <= `TXPCS_SER_DEF_CHAN; // [R10]
    end else if (ser.load) begin
      ser_chan <= ser.chan;
    end
  end

  // ----------------------------------------
  // Start-up sequencer
  // ----------------------------------------
  logic    run;
  logic    run_d;
  logic [TW-1:0] tmo_cnt;
  logic    tmo_hit;

  assign run     = pdn_s && !ctrl_hold;
  assign tmo_hit = (tmo_cnt == TW'(LOCK_TMO_CYC - 1));

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_d <= 1'b0;
    end else begin
      run_d <= run;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= txpcs_pkg::ST_OFF;
    end else if (!run) begin
      state <= txpcs_pkg::ST_OFF; // [R1]
    end else begin
      case (state)
        txpcs_pkg::ST_OFF: begin
          if (!run_d || restart) begin
            state <= txpcs_pkg::ST_START; // [R2] [R3]
          end
        end
        txpcs_pkg::ST_START: begin
          state <= txpcs_pkg::ST_PROG;
        end
        txpcs_pkg::ST_PROG: begin
          state <= txpcs_pkg::ST_WAIT;
        end
        txpcs_pkg::ST_WAIT: begin
          if (restart || (pll_serial && ser.load)) begin
            state <= txpcs_pkg::ST_START;
          end else if (tmo_hit) begin
            state <= txpcs_pkg::ST_PROG;
          end else if (lock_s) begin
            state <= txpcs_pkg::ST_READY; // [R5]
          end
        end
        txpcs_pkg::ST_READY: begin
          if (restart || (pll_serial && ser.load)) begin
            state <= txpcs_pkg::ST_START;
          end else if (!lock_s) begin
            state <= txpcs_pkg::ST_WAIT; // [R12]
          end
        end
        default: begin
          state <= txpcs_pkg::ST_OFF;
        end
      endcase
    end
  end

  // Retry programming if lock never comes within the host's fallback wait
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tmo_cnt <= '0;
    end else if (state != txpcs_pkg::ST_WAIT || tmo_hit) begin
      tmo_cnt <= '0;
    end else begin
      tmo_cnt <= tmo_cnt + TW'(1); // [R11]
    end
  end

  // ----------------------------------------
  // Synthesizer programming
  // ----------------------------------------
  // Mode is taken once per start so a stray mode change cannot retune mid-run
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pll_serial <= 1'b0;
      pll_chan   <= 8'h00;
    end else if (state == txpcs_pkg::ST_START) begin
      pll_serial <= mode_s; // [R6] [R9]
      if (mode_s) begin
        pll_chan <= (ser.load ? ser.chan : ser_chan); // [R4] [R10]
      end else begin
        pll_chan <= {5'h00, sel_s}; // [R4] [R7] [R8]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pll_prog      <= 1'b0;
      pll_enable    <= 1'b0;
      ready_to_send <= 1'b0;
    end else begin
      pll_prog      <= run && (state == txpcs_pkg::ST_PROG);
      pll_enable    <= run && (state != txpcs_pkg::ST_OFF); // [R1] [R2]
      ready_to_send <= run && (state == txpcs_pkg::ST_READY) && lock_s; // [R5] [R12]
    end
  end

  // ----------------------------------------
  // Events
  // ----------------------------------------
  always_comb begin
    ev = '0;
    ev[`TXPCS_EV_LOCKED]    = run && (state == txpcs_pkg::ST_WAIT) && lock_s && !tmo_hit;
    ev[`TXPCS_EV_LOCK_LOST] = run && (state == txpcs_pkg::ST_READY) && !lock_s;
    ev[`TXPCS_EV_SER_LOAD]  = ser.load;
    ev[`TXPCS_EV_SER_ERR]   = ser.err;
    ev[`TXPCS_EV_TIMEOUT]   = run && (state == txpcs_pkg::ST_WAIT) && tmo_hit;
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `TXPCS_REG_CTRL: begin
            reg_rdata[`TXPCS_CTRL_HOLD] <= ctrl_hold;
          end
          `TXPCS_REG_STATUS: begin
            reg_rdata[`TXPCS_ST_RTS]    <= ready_to_send;
            reg_rdata[`TXPCS_ST_SERIAL] <= pll_serial;
            reg_rdata[`TXPCS_ST_LOCK]   <= lock_s;
            reg_rdata[`TXPCS_ST_STATE_LO +: 5] <= state;
            reg_rdata[`TXPCS_ST_CHAN_LO +: 8]  <= pll_chan;
          end
          `TXPCS_REG_INT_STAT: begin
            reg_rdata[`TXPCS_EV_W-1:0] <= int_stat;
          end
          `TXPCS_REG_INT_MASK: begin
            reg_rdata[`TXPCS_EV_W-1:0] <= int_mask;
          end
          default: begin
            reg_rdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule // txpcs_top

/* File: sim/txpcs_top_assertions.sv */
`timescale 1ns/1ns
`include "txpcs_params.svh"
module txpcs_top_assertions #(
  parameter int LOCK_TMO_CYC = `TXPCS_LOCK_TMO_CYC
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       resetn,
  // Pins and synthesizer
  input wire logic       power_down_n,
  input wire logic       mode_sel,
  input wire logic       chan_sel_bit0,
  input wire logic       chan_sel_bit1,
  input wire logic       chan_sel_bit2,
  input wire logic       ready_to_send,
  input wire logic       pll_lock,
  input wire logic       pll_enable,
  input wire logic       pll_prog,
  input wire logic [7:0] pll_chan,
  input wire logic       pll_serial
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_shutdown;
    (!power_down_n)[*6] |-> !ready_to_send && !pll_enable && !pll_prog;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("active during power-down");
  property p_wake;
    power_down_n[*8] |-> pll_enable;
  endproperty
  a_wake: assert property (p_wake) else $error("synth off while awake");
  property p_restart;
    $rose(power_down_n) |-> ##[3:8] pll_prog;
  endproperty
  a_restart: assert property (p_restart) else $error("no start-up after wake");
  property p_pulse;
    pll_prog |=> !pll_prog;
  endproperty
  a_pulse: assert property (p_pulse) else $error("program pulse too long");
  property p_rts_lock;
    $rose(ready_to_send) |-> $past(pll_lock, 3) && pll_lock;
  endproperty
  a_rts_lock: assert property (p_rts_lock) else $error("ready without lock");
  property p_lock_loss;
    (!pll_lock)[*6] |-> !ready_to_send;
  endproperty
  a_lock_loss: assert property (p_lock_loss) else $error("ready held without lock");
  property p_mode;
    pll_prog && mode_sel == $past(mode_sel, 8) |-> pll_serial == mode_sel;
  endproperty
  a_mode: assert property (p_mode) else $error("wrong selection mode");
  property p_par_chan;
    pll_prog && !pll_serial |->
      pll_chan == {5'h00, $past(chan_sel_bit2, 4), $past(chan_sel_bit1, 4), $past(chan_sel_bit0, 4)};
  endproperty
  a_par_chan: assert property (p_par_chan) else $error("wrong parallel channel");
  property p_ser_def;
    $rose(power_down_n) ##[3:8] pll_prog |-> !pll_serial || pll_chan == 8'h32;
  endproperty
  a_ser_def: assert property (p_ser_def) else $error("serial default not 50");
endmodule // txpcs_top_assertions

bind txpcs_top txpcs_top_assertions #(.LOCK_TMO_CYC(LOCK_TMO_CYC)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .power_down_n(power_down_n), .mode_sel(mode_sel),
  .chan_sel_bit0(chan_sel_bit0), .chan_sel_bit1(chan_sel_bit1), .chan_sel_bit2(chan_sel_bit2),
  .ready_to_send(ready_to_send), .pll_lock(pll_lock), .pll_enable(pll_enable),
  .pll_prog(pll_prog), .pll_chan(pll_chan), .pll_serial(pll_serial));

/* File: sim/txpcs_host.sv */
`timescale 1ns/1ns
module txpcs_host (
  // Clock
  input wire logic sys_clk,
  // Control pins
  output logic     power_down_n,
  output logic     mode_sel,
  output logic     chan_sel_bit0,
  output logic     chan_sel_bit1,
  output logic     chan_sel_bit2
);
  initial begin
    power_down_n  = 1'h1;
    mode_sel      = 1'h0;
    chan_sel_bit0 = 1'h0;
    chan_sel_bit1 = 1'h0;
    chan_sel_bit2 = 1'h0;
  end

  task automatic pwr(input logic on);
    @(posedge sys_clk);
    power_down_n <= on;
  endtask

  // Full supply swing only, never a floating level
  task automatic set_par(input logic m, input logic [2:0] sel);
    @(posedge sys_clk);
    mode_sel <= m;
    {chan_sel_bit2, chan_sel_bit1, chan_sel_bit0} <= sel;
  endtask

  // Each level held 4 cycles so the synchronisers see it
  task automatic step(input logic c, input logic d);
    @(posedge sys_clk);
    chan_sel_bit1 <= c;
    chan_sel_bit2 <= d;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic ser_send(input logic [7:0] ch);
    step(1'h1, 1'h0);
    for (int i = 0; i < 8; i++) begin
      step(1'h0, ch[i]);
      step(1'h1, ch[i]);
    end
    step(1'h1, 1'h1);
  endtask
endmodule // txpcs_host

/* File: sim/txpcs_top_bench.sv */
`timescale 1ns/1ns
module txpcs_top_bench;
  typedef struct packed {logic [2:0] sel; logic [7:0] chan;} txpcs_row_t;
  logic        sys_clk, resetn, pll_lock, reg_wr, reg_rd;
  logic        power_down_n, mode_sel, chan_sel_bit0, chan_sel_bit1, chan_sel_bit2;
  logic        ready_to_send, pll_enable, pll_prog, pll_serial, irq;
  logic [7:0]  pll_chan;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  int          num_errors, samples_checked;
  txpcs_row_t  rows [8] = '{'{3'h0, 8'h00}, '{3'h1, 8'h01}, '{3'h2, 8'h02}, '{3'h3, 8'h03},
                            '{3'h4, 8'h04}, '{3'h5, 8'h05}, '{3'h6, 8'h06}, '{3'h7, 8'h07}};

  txpcs_top #(.LOCK_TMO_CYC(64)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
    .power_down_n(power_down_n), .mode_sel(mode_sel), .chan_sel_bit0(chan_sel_bit0),
    .chan_sel_bit1(chan_sel_bit1), .chan_sel_bit2(chan_sel_bit2), .ready_to_send(ready_to_send),
    .pll_lock(pll_lock), .pll_enable(pll_enable), .pll_prog(pll_prog), .pll_chan(pll_chan),
    .pll_serial(pll_serial), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  txpcs_host u_host (.sys_clk(sys_clk), .power_down_n(power_down_n), .mode_sel(mode_sel),
    .chan_sel_bit0(chan_sel_bit0), .chan_sel_bit1(chan_sel_bit1), .chan_sel_bit2(chan_sel_bit2));

  always #20 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic wait_for(input bit want_rts, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(negedge sys_clk);
      if ((want_rts ? ready_to_send : pll_prog) === 1'h1) break;
    end
    chk(32'(k < n), 32'h1, want_rts ? "ready seen" : "program seen");
    // Hand back on a rising edge so the caller drives by NBA there
    @(posedge sys_clk);
  endtask

  task automatic results;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    $display("mismatch %0t watchdog expired", $time);
    results();
  end

  initial begin
    sys_clk = 1'h0; resetn = 1'h0; pll_lock = 1'h0;
    // Address and data stay open until the first access; the low strobes gate them
    reg_wr = 1'h0; reg_rd = 1'h0;
    repeat (10) @(posedge sys_clk);
    chk(pll_enable, 1'h0, "enable in reset");
    resetn <= 1'h1;
    wait_for(0, 20);
    // --------------------------------
    // Parallel channel table
    // --------------------------------
    foreach (rows[i]) begin
      u_host.pwr(1'h0);
      pll_lock <= 1'h0;
      u_host.set_par(1'h0, rows[i].sel);
      repeat (8) @(posedge sys_clk);
      chk(pll_enable, 1'h0, "enable in power-down");
      u_host.pwr(1'h1);
      wait_for(0, 20);
      chk(pll_chan, rows[i].chan, "parallel channel");
      chk(pll_serial, 1'h0, "parallel mode");
      chk(ready_to_send, 1'h0, "ready before lock");
      pll_lock <= 1'h1;
      wait_for(1, 20);
      rd(4'h4);
      chk(d[23:16], rows[i].chan, "status channel");
    end
    // --------------------------------
    // Interrupt, unmapped, serial, timeout
    // --------------------------------
    chk(irq, 1'h0, "masked event");
    wr(4'hc, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'h1, "unmasked event");
    wr(4'h8, 32'h1f);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'h0, "cleared event");
    rd(4'h2);
    chk(d, 32'h0, "unmapped read");
    wr(4'hc, 32'h8);
    pll_lock <= 1'h0;
    u_host.pwr(1'h0);
    u_host.set_par(1'h1, 3'h7);
    wr(4'h0, 32'h1);
    rd(4'h0);
    chk(d, 32'h1, "hold readback");
    wr(4'h0, 32'h0);
    repeat (8) @(posedge sys_clk);
    u_host.pwr(1'h1);
    wait_for(0, 20);
    chk(pll_chan, 8'h32, "serial default");
    chk(pll_serial, 1'h1, "serial mode");
    pll_lock <= 1'h1;
    wait_for(1, 20);
    u_host.ser_send(8'h17);
    repeat (20) @(posedge sys_clk);
    chk(pll_chan, 8'h17, "serial load");
    chk(ready_to_send, 1'h1, "ready after reload");
    u_host.ser_send(8'h65);
    repeat (20) @(posedge sys_clk);
    chk(pll_chan, 8'h00, "bad serial load");
    chk(irq, 1'h1, "load error irq");
    rd(4'h8);
    chk(d, 32'h0000_000f, "lock, loss, load and error events");
    // Restart reprograms the held channel without a power cycle
    wr(4'h0, 32'h2);
    wait_for(0, 20);
    chk(pll_chan, 8'h00, "restart channel");
    rd(4'h0);
    chk(d, 32'h0, "restart reads zero");
    wr(4'h8, 32'h8);
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'h0, "load error cleared");
    pll_lock <= 1'h0;
    repeat (8) @(posedge sys_clk);
    chk(ready_to_send, 1'h0, "ready after lock loss");
    wait_for(0, 150);
    rd(4'h8);
    chk(d[4], 1'h1, "lock timeout event");
    results();
  end
endmodule // txpcs_top_bench
